// ==== logic/cho_manual_regs.vh ====
`ifndef CHO_MANUAL_REGS_VH
`define CHO_MANUAL_REGS_VH
// apb register byte offsets
`define ADDR_SWITCHES 12'h000
`define ADDR_REMOTE 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_CONFIG 12'h00C
`define ADDR_LEDS 12'h010
`define ADDR_EVENTS 12'h014
// switch bit positions (dip n at bit n-1)
`define SW_PRIORITY 1
`define SW_LOCK_LO 3
`define SW_LOCK_HI 4
`define SW_AUDIO_GEN 5
`define SW_EMBED 6
`define SW_GPIO_STYLE 7
// multi-bit fields: the lowest numbered switch is the msb
`define SW_DELAY_LO 8
`define SW_DELAY_MID 9
`define SW_DELAY_HI 10
`define SW_OUT1 11
`define SW_OUT2 12
`define SW_VIDGEN 13
`define SW_RESET 14
`define SW_OVERRIDE 15
// lock and hold codes
`define HOLD_MIN 2'h0
`define HOLD_1S 2'h1
`define HOLD_4S 2'h2
// led colour codes
`define LED_OFF 2'h0
`define LED_RED 2'h1
`define LED_ORANGE 2'h2
`define LED_GREEN 2'h3
// timing
`define CLK_HZ 200000000
`define SYNC_SETTLE 2'h2
`define HOLD_1S_MS 1000
`define HOLD_4S_MS 4000
`define FLICKER_MS 100
`define SLOW_FLASH_MS 500
`define RUN_STEP_MS 250
`endif

// ==== logic/cho_manual_ctrl.v ====
// Function
// - lock/hold code min, 1s, 4s, reserved
// - audio generator sine or black sound
// - embedding switch passes or embeds audio
// - gpio style: change-over or frame-sync
// - three-bit frame delay zero to seven
// - output switches pick through or processed
// - video generator bars or black field
// - factory reset armed then executed later
// - override switch sampled at power-up only
// - missing audio group routes to fallback
// - card led red orange green
// - video input led by lock state
// - sync input led by lock state
// - audio led by group count
// - unpacking shows orange running light
// - locate flashes all leds orange
// - phase limit and zero flicker leds in manual mode
// - status pin conducts when error-free
// - loss pin on selected input loss
// - pin 3 input one or sync loss
// - pins 4 and 7 input two or delay pulse
`timescale 1ns/1ps
`include "cho_manual_regs.vh"
module cho_manual_ctrl #(
   parameter HOLD_1S_CYC = `CLK_HZ / 1000 * `HOLD_1S_MS,
   parameter HOLD_4S_CYC = `CLK_HZ / 1000 * `HOLD_4S_MS,
   parameter FLICKER_CYC = `CLK_HZ / 1000 * `FLICKER_MS,
   parameter FLASH_CYC = `CLK_HZ / 1000 * `SLOW_FLASH_MS,
   parameter STEP_CYC = `CLK_HZ / 1000 * `RUN_STEP_MS,
   parameter FRAME_CYC = 32'd8000000
)(
   input wire CLOCK, // system clock
   input wire RST, // async reset, high
   input wire [15:0] DIP_SWITCHES, // raw switches, on = 1
   input wire [3:0] CARD_FAULTS, // fuse, load fail, unprogrammed, fw update
   input wire UNPACKING, // firmware unpacking stage
   input wire [1:0] INPUT_PRESENT, // video present per input
   input wire [1:0] INPUT_LOCKED, // oscillator locked per input
   input wire SYNC_PRESENT, // reference present
   input wire SYNC_LOCKED, // reference locked
   input wire [3:0] AUDIO_GROUPS, // embedded groups present
   input wire MODULE_ERROR, // general module error
   input wire PHASE_LIMIT_LOW, // phase reached lower limit pulse
   input wire PHASE_LIMIT_HIGH, // phase reached upper limit pulse
   input wire PHASE_ZEROED, // both buttons pressed pulse
   input wire FRAME_START, // frame start pulse
   input wire GPI_RESET_N, // pin 5, active low
   input wire GPI_SET_N, // pin 6, active low
   input wire [31:0] PADDR, // apb address
   input wire PSEL, // apb select
   input wire PENABLE, // apb enable
   input wire PWRITE, // apb direction
   input wire [31:0] PWDATA, // apb write data
   output reg [31:0] PRDATA, // apb read data
   output reg PREADY, // apb ready
   output reg PSLVERR, // apb error
   output reg MAIN_IS_SECOND, // main input is input two
   output reg [1:0] HOLD_CODE, // effective lock/hold code
   output reg HOLD_VALID, // code not reserved and latched
   output reg AUDIO_BLACK_SOUND, // generator is black sound
   output reg EMBED_ENABLE, // embed configured audio
   output reg FRAME_SYNC_STYLE, // gpio style frame-sync
   output reg [2:0] FRAME_DELAY, // frames of delay
   output reg [1:0] OUT_PROCESSED, // per output processed path
   output reg GEN_BLACK_FIELD, // fallback black field
   output reg MANUAL_MODE, // override caught at power-up
   output reg FACTORY_RESET_ARMED, // reset armed, start-up halted
   output reg FACTORY_RESET_GO, // execute factory reset
   output reg [3:0] AUDIO_FALLBACK, // per group use fallback
   output reg SELECT_SECOND, // current input is input two
   output reg [7:0] LEDS, // four leds, two bits each
   output reg GPI_OUT1_OE, // pin 1 pull-down
   output reg GPI_OUT2_OE, // pin 2 pull-down
   output reg GPI_OUT3_OE, // pin 3 pull-down
   output reg GPI_OUT4_OE, // pin 4 pull-down
   output reg GPI_OUT7_OE // pin 7 pull-down
);
   reg [15:0] sw_meta, sw;
   reg [1:0] gpi_meta, gpi;
   reg [1:0] pres_meta, pres, lock_meta, lock;
   reg boot_done, prev_armed, remote_style;
   reg latch_enable, locate;
   reg [31:0] flick_cnt, flash_cnt, step_cnt, pulse_cnt;
   reg [1:0] flick_kind, run_pos, settle;
   reg flash_phase, clear_armed_nv;
   reg [7:0] next_leds;
   wire input_loss;
   wire [2:0] ngroups;
   wire apb_go = PSEL & PENABLE & ~PREADY;
   wire [11:0] addr = PADDR[11:0];
   // two-flop sync of switches, pins and input status
   // sync control inputs
   always @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         sw_meta <= 16'h0000;
         sw <= 16'h0000;
         gpi_meta <= 2'h3;
         gpi <= 2'h3;
         pres_meta <= 2'h0;
         pres <= 2'h0;
         lock_meta <= 2'h0;
         lock <= 2'h0;
      end
      else
      begin
         sw_meta <= DIP_SWITCHES;
         sw <= sw_meta;
         gpi_meta <= {GPI_SET_N, GPI_RESET_N};
         gpi <= gpi_meta;
         pres_meta <= INPUT_PRESENT;
         pres <= pres_meta;
         lock_meta <= INPUT_LOCKED;
         lock <= lock_meta;
      end
   end
   // power-up sampling of override and reset switches, once the switch sync has filled
   always @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         boot_done <= 1'b0;
         settle <= 2'h0;
         MANUAL_MODE <= 1'b0;
         FACTORY_RESET_ARMED <= 1'b0;
         FACTORY_RESET_GO <= 1'b0;
      end
      else if (!boot_done && settle == `SYNC_SETTLE)
      begin
         boot_done <= 1'b1;
         MANUAL_MODE <= sw[`SW_OVERRIDE];
         FACTORY_RESET_ARMED <= sw[`SW_RESET] & sw[`SW_OVERRIDE];
         FACTORY_RESET_GO <= prev_armed & ~sw[`SW_RESET];
      end
      else if (!boot_done)
         settle <= settle + 2'h1;
      else
      begin
         FACTORY_RESET_GO <= 1'b0;
      end
   end
   // armed flag survives reset, standing for non-volatile storage
   always @(posedge CLOCK)
   begin
      if (boot_done && FACTORY_RESET_ARMED)
         prev_armed <= 1'b1;
      else if (boot_done && clear_armed_nv)
         prev_armed <= 1'b0;
      else if (prev_armed !== 1'b1)
         prev_armed <= 1'b0;
   end
   // decode of manual switches, remote settings otherwise
   always @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         MAIN_IS_SECOND <= 1'b0;
         HOLD_CODE <= `HOLD_MIN;
         HOLD_VALID <= 1'b0;
         AUDIO_BLACK_SOUND <= 1'b0;
         EMBED_ENABLE <= 1'b0;
         FRAME_SYNC_STYLE <= 1'b0;
         FRAME_DELAY <= 3'h0;
         OUT_PROCESSED <= 2'h0;
         GEN_BLACK_FIELD <= 1'b0;
         clear_armed_nv <= 1'b0;
      end
      else if (MANUAL_MODE)
      begin
         MAIN_IS_SECOND <= sw[`SW_PRIORITY];
         HOLD_CODE <= {sw[`SW_LOCK_LO], sw[`SW_LOCK_HI]};
         HOLD_VALID <= latch_enable & (sw[`SW_LOCK_HI:`SW_LOCK_LO] != 2'h3);
         AUDIO_BLACK_SOUND <= sw[`SW_AUDIO_GEN];
         EMBED_ENABLE <= sw[`SW_EMBED];
         FRAME_SYNC_STYLE <= sw[`SW_GPIO_STYLE];
         FRAME_DELAY <= {sw[`SW_DELAY_LO], sw[`SW_DELAY_MID], sw[`SW_DELAY_HI]};
         OUT_PROCESSED <= sw[`SW_OUT2:`SW_OUT1];
         GEN_BLACK_FIELD <= sw[`SW_VIDGEN];
         clear_armed_nv <= FACTORY_RESET_GO;
      end
      else
      begin
         FRAME_SYNC_STYLE <= remote_style;
         HOLD_VALID <= latch_enable & (HOLD_CODE != 2'h3);
         clear_armed_nv <= FACTORY_RESET_GO;
      end
   end
   // input selection forced by the control pins
   always @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         SELECT_SECOND <= 1'b0;
      // pin 5 low back to main
      else if (!gpi[0])
         SELECT_SECOND <= MAIN_IS_SECOND;
      else if (!gpi[1])
         SELECT_SECOND <= ~MAIN_IS_SECOND;
      else if (!boot_done)
         SELECT_SECOND <= sw[`SW_OVERRIDE] & sw[`SW_PRIORITY]; // start on the main input
   end
   always @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         AUDIO_FALLBACK <= 4'h0;
      else
         AUDIO_FALLBACK <= ~AUDIO_GROUPS;
   end
   assign input_loss = SELECT_SECOND ? ~(pres[1] & lock[1]) : ~(pres[0] & lock[0]);
   // frame delay pulse, length in frames
   always @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         pulse_cnt <= 32'h0;
      else if (FRAME_START)
         pulse_cnt <= FRAME_CYC * {29'h0, FRAME_DELAY};
      else if (pulse_cnt != 32'h0)
         pulse_cnt <= pulse_cnt - 32'h1;
   end
   // open-collector outputs as pull-down enables
   // pull-down enable model
   always @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         GPI_OUT1_OE <= 1'b0;
         GPI_OUT2_OE <= 1'b0;
         GPI_OUT3_OE <= 1'b0;
         GPI_OUT4_OE <= 1'b0;
         GPI_OUT7_OE <= 1'b0;
      end
      else
      begin
         GPI_OUT1_OE <= ~MODULE_ERROR;
         GPI_OUT2_OE <= input_loss;
         GPI_OUT3_OE <= FRAME_SYNC_STYLE ? ~(SYNC_PRESENT & SYNC_LOCKED) : ~SELECT_SECOND;
         // input two or delay pulse, pin 7 same
         GPI_OUT4_OE <= FRAME_SYNC_STYLE ? (pulse_cnt != 32'h0) : SELECT_SECOND;
         GPI_OUT7_OE <= FRAME_SYNC_STYLE ? (pulse_cnt != 32'h0) : SELECT_SECOND;
      end
   end
   // led timers: flicker, slow flash, running light
   always @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         flick_cnt <= 32'h0;
         flick_kind <= 2'h0;
         flash_cnt <= 32'h0;
         flash_phase <= 1'b0;
         step_cnt <= 32'h0;
         run_pos <= 2'h0;
      end
      else
      begin
         // start flicker on limit or zero
         if (MANUAL_MODE && (PHASE_LIMIT_LOW | PHASE_LIMIT_HIGH | PHASE_ZEROED))
         begin
            flick_cnt <= FLICKER_CYC;
            flick_kind <= PHASE_ZEROED ? 2'h3 : (PHASE_LIMIT_HIGH ? 2'h2 : 2'h1);
         end
         else if (flick_cnt != 32'h0)
            flick_cnt <= flick_cnt - 32'h1;
         if (flash_cnt >= FLASH_CYC - 1)
         begin
            flash_cnt <= 32'h0;
            flash_phase <= ~flash_phase;
         end
         else
            flash_cnt <= flash_cnt + 32'h1;
         if (step_cnt >= STEP_CYC - 1)
         begin
            step_cnt <= 32'h0;
            run_pos <= run_pos + 2'h1;
         end
         else
            step_cnt <= step_cnt + 32'h1;
      end
   end
   assign ngroups = {2'h0, AUDIO_GROUPS[0]} + {2'h0, AUDIO_GROUPS[1]}
      + {2'h0, AUDIO_GROUPS[2]} + {2'h0, AUDIO_GROUPS[3]};
   // led colours, special patterns last so they override
   always @*
   begin
      if (CARD_FAULTS[0] | CARD_FAULTS[1])
         next_leds[1:0] = `LED_RED;
      else if (CARD_FAULTS[2] | CARD_FAULTS[3] | FACTORY_RESET_ARMED)
         next_leds[1:0] = `LED_ORANGE;
      else
         next_leds[1:0] = `LED_GREEN;
      if (SELECT_SECOND ? ~pres[1] : ~pres[0])
         next_leds[3:2] = `LED_RED;
      else if (input_loss)
         next_leds[3:2] = `LED_ORANGE;
      else
         next_leds[3:2] = `LED_GREEN;
      if (!SYNC_PRESENT)
         next_leds[5:4] = `LED_RED;
      else if (!SYNC_LOCKED)
         next_leds[5:4] = `LED_ORANGE;
      else
         next_leds[5:4] = `LED_GREEN;
      if (ngroups == 3'h0)
         next_leds[7:6] = `LED_RED;
      else if (ngroups == 3'h4)
         next_leds[7:6] = `LED_GREEN;
      else
         next_leds[7:6] = `LED_ORANGE;
      if (flick_cnt != 32'h0) // brief blank while the flicker runs
      begin
         if (flick_kind == 2'h1)
            next_leds[1:0] = `LED_OFF;
         else if (flick_kind == 2'h2)
            next_leds[7:6] = `LED_OFF;
         else
            next_leds[5:2] = {`LED_OFF, `LED_OFF};
      end
      if (locate)
         next_leds = flash_phase ? {4{`LED_ORANGE}} : {4{`LED_OFF}};
      if (UNPACKING)
      begin
         next_leds = {4{`LED_ORANGE}};
         next_leds[run_pos*2 +: 2] = `LED_OFF;
      end
   end
   // led register
   always @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         LEDS <= 8'h00;
      else
         LEDS <= next_leds;
   end
   // apb slave, one wait state, unmapped reads zero with error
   always @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         PRDATA <= 32'h0;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         remote_style <= 1'b0;
         latch_enable <= 1'b1;
         locate <= 1'b0;
      end
      else
      begin
         PREADY <= apb_go;
         PSLVERR <= 1'b0;
         if (apb_go)
         begin
            PRDATA <= 32'h0;
            case (addr)
               `ADDR_SWITCHES: PRDATA <= {16'h0, sw};
               `ADDR_REMOTE:
               begin
                  if (PWRITE)
                  begin
                     remote_style <= PWDATA[0];
                     locate <= PWDATA[1];
                     latch_enable <= PWDATA[2];
                  end
                  PRDATA <= {29'h0, latch_enable, locate, remote_style};
               end
               `ADDR_STATUS: PRDATA <= {18'h0, AUDIO_FALLBACK, pres, lock,
                  2'h0, FACTORY_RESET_ARMED, MANUAL_MODE, input_loss, SELECT_SECOND};
               `ADDR_CONFIG: PRDATA <= {16'h0, GEN_BLACK_FIELD, OUT_PROCESSED,
                  FRAME_DELAY, FRAME_SYNC_STYLE, EMBED_ENABLE, AUDIO_BLACK_SOUND,
                  HOLD_VALID, HOLD_CODE, MAIN_IS_SECOND, 3'h0};
               `ADDR_LEDS: PRDATA <= {24'h0, LEDS};
               default: PSLVERR <= 1'b1;
            endcase
         end
      end
   end
endmodule // cho_manual_ctrl

// ==== tb/cho_manual_chk.sv ====
`timescale 1ns/1ps
module cho_manual_chk (
   input wire CLOCK, // system clock
   input wire RST, // async reset
   input wire MODULE_ERROR, // error level
   input wire [1:0] INPUT_PRESENT, // video present
   input wire GPI_RESET_N, // pin 5
   input wire GPI_SET_N, // pin 6
   input wire MAIN_IS_SECOND, // main is two
   input wire SELECT_SECOND, // selected is two
   input wire FRAME_SYNC_STYLE, // gpio style
   input wire FACTORY_RESET_GO, // go pulse
   input wire GPI_OUT1_OE, // pin 1
   input wire GPI_OUT2_OE, // pin 2
   input wire GPI_OUT3_OE, // pin 3
   input wire GPI_OUT4_OE, // pin 4
   input wire GPI_OUT7_OE // pin 7
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   AST_STATUS_PIN: assert property (MODULE_ERROR |=> !GPI_OUT1_OE)
      else $error("status pin pulled during error");
   AST_LOSS_PIN: assert property ((INPUT_PRESENT == 2'h0) [*4] |-> GPI_OUT2_OE)
      else $error("loss pin idle with no input");
   AST_CO_FIRST: assert property ((!FRAME_SYNC_STYLE && !SELECT_SECOND) [*3]
      |-> GPI_OUT3_OE && !GPI_OUT4_OE) else $error("pin 3 wrong for input one");
   AST_CO_SECOND: assert property ((!FRAME_SYNC_STYLE && SELECT_SECOND) [*3]
      |-> GPI_OUT4_OE && !GPI_OUT3_OE) else $error("pin 4 wrong for input two");
   AST_PIN_SEVEN: assert property (GPI_OUT7_OE == GPI_OUT4_OE)
      else $error("pin 7 differs from pin 4");
   AST_SET_STBY: assert property ((!GPI_SET_N && GPI_RESET_N && !MAIN_IS_SECOND) [*4]
      |-> SELECT_SECOND) else $error("set input ignored");
   AST_RESET_MAIN: assert property ((!GPI_RESET_N && !MAIN_IS_SECOND) [*4]
      |-> !SELECT_SECOND) else $error("reset input ignored");
   AST_GO_PULSE: assert property (FACTORY_RESET_GO |=> !FACTORY_RESET_GO)
      else $error("factory reset go too long");
   // main scenarios reached
   COV_SET: cover property (!GPI_SET_N ##4 SELECT_SECOND);
   COV_GO: cover property (FACTORY_RESET_GO);
   COV_LOSS: cover property (GPI_OUT2_OE);
endmodule // cho_manual_chk

bind cho_manual_ctrl cho_manual_chk chk_u (.CLOCK(CLOCK), .RST(RST),
   .MODULE_ERROR(MODULE_ERROR), .INPUT_PRESENT(INPUT_PRESENT), .GPI_RESET_N(GPI_RESET_N),
   .GPI_SET_N(GPI_SET_N), .MAIN_IS_SECOND(MAIN_IS_SECOND), .SELECT_SECOND(SELECT_SECOND),
   .FRAME_SYNC_STYLE(FRAME_SYNC_STYLE), .FACTORY_RESET_GO(FACTORY_RESET_GO),
   .GPI_OUT1_OE(GPI_OUT1_OE), .GPI_OUT2_OE(GPI_OUT2_OE), .GPI_OUT3_OE(GPI_OUT3_OE),
   .GPI_OUT4_OE(GPI_OUT4_OE), .GPI_OUT7_OE(GPI_OUT7_OE));

// ==== tb/gpi_far_end.sv ====
`timescale 1ns/1ps
module gpi_far_end (
   input wire clock, // system clock
   input wire [4:0] pull_oe, // pins 1,2,3,4,7
   input wire ask_main, // want main input
   input wire ask_stby, // want standby input
   output reg reset_n = 1'b1, // pin 5, idle high
   output reg set_n = 1'b1, // pin 6, idle high
   output wire [4:0] pin_level // pins with pull-up
);
   always @(posedge clock)
   begin
      reset_n <= !ask_main;
      set_n <= !ask_stby;
   end
   assign pin_level = ~pull_oe;
endmodule // gpi_far_end

// ==== tb/cho_manual_ctrl_bench.sv ====
`timescale 1ns/1ps
`include "cho_manual_regs.vh"
module cho_manual_ctrl_bench;
   logic CLOCK = 1'b0, RST = 1'b1, UNPACKING = 1'b0, SYNC_PRESENT = 1'b1, SYNC_LOCKED = 1'b1;
   logic MODULE_ERROR = 1'b0, FRAME_START = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [15:0] DIP_SWITCHES = 16'h0000;
   logic [3:0] CARD_FAULTS = 4'h0, AUDIO_GROUPS = 4'hF, AUDIO_FALLBACK;
   logic [1:0] INPUT_PRESENT = 2'h3, INPUT_LOCKED = 2'h3, HOLD_CODE, OUT_PROCESSED;
   logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, PRDATA, rd;
   logic PREADY, PSLVERR, MAIN_IS_SECOND, HOLD_VALID, AUDIO_BLACK_SOUND, EMBED_ENABLE;
   logic FRAME_SYNC_STYLE, GEN_BLACK_FIELD, MANUAL_MODE, FACTORY_RESET_ARMED, FACTORY_RESET_GO;
   logic SELECT_SECOND, o1, o2, o3, o4, o7, rst_n, set_n, ask_main = 1'b0, ask_stby = 1'b0;
   logic [2:0] FRAME_DELAY;
   logic [7:0] LEDS;
   logic [4:0] pin;
   logic err, go, ph_lo = 1'b0, ph_hi = 1'b0, ph_zero = 1'b0;
   logic [13:0] stim [4] = '{14'h0001, 14'h3218, 14'h3FF0, 14'h3F72};
   logic [7:0] lexp [4] = '{8'h55, 8'hAA, 8'hFF, 8'hBD};
   int mismatches = 0, check_count = 0, n, miss, chg;
   // 200 MHz clock
   always #2.5 CLOCK = ~CLOCK;
   cho_manual_ctrl #(.FLICKER_CYC(8), .FLASH_CYC(8),
      .STEP_CYC(8), .FRAME_CYC(20)) dut_u (.CLOCK(CLOCK), .RST(RST),
      .DIP_SWITCHES(DIP_SWITCHES), .CARD_FAULTS(CARD_FAULTS), .UNPACKING(UNPACKING),
      .INPUT_PRESENT(INPUT_PRESENT), .INPUT_LOCKED(INPUT_LOCKED), .SYNC_PRESENT(SYNC_PRESENT),
      .SYNC_LOCKED(SYNC_LOCKED), .AUDIO_GROUPS(AUDIO_GROUPS), .MODULE_ERROR(MODULE_ERROR),
      .PHASE_LIMIT_LOW(ph_lo), .PHASE_LIMIT_HIGH(ph_hi), .PHASE_ZEROED(ph_zero),
      .FRAME_START(FRAME_START), .GPI_RESET_N(rst_n), .GPI_SET_N(set_n), .PADDR(PADDR),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .MAIN_IS_SECOND(MAIN_IS_SECOND),
      .HOLD_CODE(HOLD_CODE), .HOLD_VALID(HOLD_VALID), .AUDIO_BLACK_SOUND(AUDIO_BLACK_SOUND),
      .EMBED_ENABLE(EMBED_ENABLE), .FRAME_SYNC_STYLE(FRAME_SYNC_STYLE),
      .FRAME_DELAY(FRAME_DELAY), .OUT_PROCESSED(OUT_PROCESSED),
      .GEN_BLACK_FIELD(GEN_BLACK_FIELD), .MANUAL_MODE(MANUAL_MODE),
      .FACTORY_RESET_ARMED(FACTORY_RESET_ARMED), .FACTORY_RESET_GO(FACTORY_RESET_GO),
      .AUDIO_FALLBACK(AUDIO_FALLBACK), .SELECT_SECOND(SELECT_SECOND), .LEDS(LEDS),
      .GPI_OUT1_OE(o1), .GPI_OUT2_OE(o2), .GPI_OUT3_OE(o3), .GPI_OUT4_OE(o4), .GPI_OUT7_OE(o7));
   gpi_far_end far_u (.clock(CLOCK), .pull_oe({o7, o4, o3, o2, o1}), .ask_main(ask_main),
      .ask_stby(ask_stby), .reset_n(rst_n), .set_n(set_n), .pin_level(pin));
   // verdict and end of run
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count = check_count + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer
   task automatic bus(input logic w, input logic [31:0] a, d);
      int k;
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      k = 0;
      do
      begin
         @(posedge CLOCK);
         k = k + 1;
      end
      while (PREADY !== 1'b1 && k < 50);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (k >= 50)
      begin
         mismatches = mismatches + 1;
         $display("MISMATCH at %0t: no ready", $time);
         conclude();
      end
   endtask
   // power-up with switches, watch go
   task automatic boot(input logic [15:0] dip);
      @(posedge CLOCK);
      RST <= 1'b1;
      DIP_SWITCHES <= dip;
      repeat (2) @(posedge CLOCK);
      RST <= 1'b0;
      go = 1'b0;
      repeat (8)
      begin
         @(posedge CLOCK);
         if (FACTORY_RESET_GO === 1'b1)
            go = 1'b1;
      end
   endtask
   // led pattern from a set of four
   task automatic watch(input logic [31:0] s);
      logic [7:0] last;
      repeat (4) @(posedge CLOCK);
      miss = 0;
      chg = 0;
      last = LEDS;
      repeat (48)
      begin
         @(posedge CLOCK);
         if (LEDS !== s[7:0] && LEDS !== s[15:8] && LEDS !== s[23:16] && LEDS !== s[31:24])
            miss = miss + 1;
         if (LEDS !== last)
            chg = chg + 1;
         last = LEDS;
      end
      chk(miss, 0);
      chk(chg > 1, 1);
   endtask
   // main sequence
   initial
   begin
      boot(16'h91BA);
      chk({MAIN_IS_SECOND, AUDIO_BLACK_SOUND, EMBED_ENABLE, FRAME_SYNC_STYLE, FRAME_DELAY,
         OUT_PROCESSED, GEN_BLACK_FIELD, HOLD_VALID, MANUAL_MODE}, 12'hD91); // 8
      DIP_SWITCHES <= 16'h11BA;
      repeat (6) @(posedge CLOCK);
      chk(MANUAL_MODE, 1'b1);
      ph_lo <= 1'b1;
      @(posedge CLOCK);
      ph_lo <= 1'b0;
      repeat (3) @(posedge CLOCK);
      chk(LEDS, 8'hFC);
      ph_zero <= 1'b1;
      @(posedge CLOCK);
      ph_zero <= 1'b0;
      repeat (3) @(posedge CLOCK);
      chk(LEDS, 8'hC3);
      ph_hi <= 1'b1;
      @(posedge CLOCK);
      ph_hi <= 1'b0;
      repeat (3) @(posedge CLOCK);
      chk(LEDS, 8'h3F);
      repeat (12) @(posedge CLOCK);
      chk(LEDS, 8'hFF);
      SYNC_PRESENT <= 1'b0;
      repeat (6) @(posedge CLOCK);
      chk(pin[2], 1'b0);
      SYNC_PRESENT <= 1'b1;
      FRAME_START <= 1'b1;
      @(posedge CLOCK);
      FRAME_START <= 1'b0;
      n = 0;
      repeat (400)
      begin
         @(posedge CLOCK);
         n = n + (o4 === 1'b1);
      end
      chk(n, 80);
      boot(16'hA848);
      chk(go, 1'b0);
      chk({MAIN_IS_SECOND, AUDIO_BLACK_SOUND, EMBED_ENABLE, FRAME_SYNC_STYLE, FRAME_DELAY,
         OUT_PROCESSED, GEN_BLACK_FIELD, HOLD_VALID, HOLD_CODE}, 13'h41E); // 8
      ask_stby <= 1'b1;
      repeat (8) @(posedge CLOCK);
      chk({SELECT_SECOND, pin[3], pin[2]}, 3'h5);
      ask_main <= 1'b1;
      repeat (8) @(posedge CLOCK);
      chk({SELECT_SECOND, pin[3], pin[2]}, 3'h2);
      ask_main <= 1'b0;
      ask_stby <= 1'b0;
      MODULE_ERROR <= 1'b1;
      INPUT_PRESENT <= 2'h0;
      repeat (8) @(posedge CLOCK);
      chk(pin[1:0], 2'h1);
      MODULE_ERROR <= 1'b0;
      INPUT_PRESENT <= 2'h3;
      repeat (30) @(posedge CLOCK);
      chk(pin[1:0], 2'h2);
      for (int i = 0; i < 4; i++)
      begin
         {INPUT_PRESENT, INPUT_LOCKED, SYNC_PRESENT, SYNC_LOCKED, AUDIO_GROUPS, CARD_FAULTS}
            <= stim[i];
         repeat (10) @(posedge CLOCK);
         chk(LEDS, lexp[i]);
      end
      chk(AUDIO_FALLBACK, 4'h8);
      CARD_FAULTS <= 4'h0;
      bus(1'b1, `ADDR_REMOTE, 32'h6);
      watch(32'hAA00AA00);
      bus(1'b1, `ADDR_REMOTE, 32'h4);
      UNPACKING <= 1'b1;
      watch(32'h2A8AA2A8);
      UNPACKING <= 1'b0;
      boot(16'h0000);
      chk(MANUAL_MODE, 1'b0);
      bus(1'b0, `ADDR_REMOTE, 32'h0);
      chk({err, rd}, 33'h4);
      bus(1'b1, `ADDR_REMOTE, 32'h5);
      repeat (4) @(posedge CLOCK);
      chk(FRAME_SYNC_STYLE, 1'b1);
      bus(1'b1, 32'h20, 32'hF);
      chk(err, 1'b1);
      bus(1'b0, 32'h20, 32'h0);
      chk({err, rd}, 33'h100000000);
      boot(16'hC000);
      chk({FACTORY_RESET_ARMED, LEDS[1:0]}, {1'b1, `LED_ORANGE});
      boot(16'h8000);
      chk(go, 1'b1);
      conclude();
   end
endmodule // cho_manual_ctrl_bench
